// ---- capture_consts.vh ----
// constants of the high-speed capture port: register map, fields, timing
// assumes inclusion by the capture port and its clock divider only
`ifndef CAPTURE_CONSTS_VH
`define CAPTURE_CONSTS_VH

// register addresses as seen on the register port
`define CAP_ADDR_CONFIG      16'hE706
`define CAP_ADDR_STATUS      16'hE7F0

// capture_port_config fields
`define CAP_BIT_CLK_SEL      0
`define CAP_BIT_SIZE_SEL     1
`define CAP_BIT_GAP_EN       2
`define CAP_BIT_CONTENT_LO   3
`define CAP_BIT_CONTENT_HI   4
`define CAP_BIT_POLARITY     5
`define CAP_CONFIG_RESET     6'h00

// status fields
`define CAP_BIT_BUSY         0

// content select codes
`define CAP_CONTENT_ALL      2'h0
`define CAP_CONTENT_WAVE     2'h1
`define CAP_CONTENT_POWER    2'h2

// word positions in the full sequence
`define CAP_IDX_FIRST_WAVE   4'h0
`define CAP_IDX_LAST_WAVE    4'h6
`define CAP_IDX_FIRST_POWER  4'h7
`define CAP_IDX_LAST_POWER   4'hF

// package lengths in bits
`define CAP_PKG_LEN_WORD     6'h20
`define CAP_PKG_LEN_BYTE     6'h08

// timing
`define CAP_REF_PERIOD_NS    40
`define CAP_FAST_PERIOD_NS   125
`define CAP_SLOW_PERIOD_NS   250
`define CAP_FAST_CYCLES      (`CAP_FAST_PERIOD_NS / `CAP_REF_PERIOD_NS)
`define CAP_SLOW_CYCLES      (`CAP_SLOW_PERIOD_NS / `CAP_REF_PERIOD_NS)
`define CAP_GAP_PERIODS      3'h7

`endif

// ---- capture_clk_div.v ----
// serial clock divider of the capture port
// assumes run_in and hold_in come from logic on ref_clk_in
`timescale 1ns/100ps
`default_nettype none
`include "capture_consts.vh"

module capture_clk_div #(
    parameter FAST_CYCLES = `CAP_FAST_CYCLES,
    parameter SLOW_CYCLES = `CAP_SLOW_CYCLES
) (
    // clock and reset
    input  wire       ref_clk_in,
    input  wire       rst_in,
    // control
    input  wire       run_in,
    input  wire       hold_in,
    input  wire       slow_sel_in,
    // outputs
    output wire       tick_out,
    output reg        sclk_out
);

    reg  [3:0] cnt_q;
    wire [3:0] period;
    wire [3:0] half;

    // odd periods get the shorter half low, so fast mode is 1 low, 2 high
    assign period = slow_sel_in ? SLOW_CYCLES[3:0] : FAST_CYCLES[3:0];
    assign half   = {1'b0, period[3:1]};
    assign tick_out = run_in && (cnt_q == 4'h0);

    always @(posedge ref_clk_in) begin
        if (rst_in || !run_in) begin
            cnt_q    <= 4'h0;
            sclk_out <= 1'b1;
        end else begin
            cnt_q    <= (cnt_q == period - 4'h1) ? 4'h0 : cnt_q + 4'h1;
            // hold stops a stray falling edge after the last bit
            sclk_out <= hold_in ? 1'b1 : (cnt_q >= half);
        end
    end

endmodule // capture_clk_div

`default_nettype wire

// ---- high_speed_capture_port.v ----
// high-speed capture port: config register, word sequencer, serialiser
// assumes one 25 MHz clock and a single-cycle register port on it
`timescale 1ns/100ps
`default_nettype none
`include "capture_consts.vh"

module high_speed_capture_port #(
    parameter WORD_W = 32,
    parameter N_WORDS = 16
) (
    // clock and reset
    input  wire              ref_clk_in,
    input  wire              rst_in,
    // register port
    input  wire [15:0]       reg_addr_in,
    input  wire [7:0]        reg_wdata_in,
    input  wire              reg_wr_in,
    input  wire              reg_rd_in,
    output reg  [7:0]        reg_rdata_out,
    // capture trigger
    input  wire              capture_start_in,
    // waveform samples
    input  wire [WORD_W-1:0] phase_a_current_sample_in,
    input  wire [WORD_W-1:0] phase_a_voltage_sample_in,
    input  wire [WORD_W-1:0] phase_b_current_sample_in,
    input  wire [WORD_W-1:0] phase_b_voltage_sample_in,
    input  wire [WORD_W-1:0] phase_c_current_sample_in,
    input  wire [WORD_W-1:0] phase_c_voltage_sample_in,
    input  wire [WORD_W-1:0] neutral_current_sample_in,
    // phase powers
    input  wire [WORD_W-1:0] phase_a_apparent_power_in,
    input  wire [WORD_W-1:0] phase_b_apparent_power_in,
    input  wire [WORD_W-1:0] phase_c_apparent_power_in,
    input  wire [WORD_W-1:0] phase_a_active_power_in,
    input  wire [WORD_W-1:0] phase_b_active_power_in,
    input  wire [WORD_W-1:0] phase_c_active_power_in,
    input  wire [WORD_W-1:0] phase_a_reactive_power_in,
    input  wire [WORD_W-1:0] phase_b_reactive_power_in,
    input  wire [WORD_W-1:0] phase_c_reactive_power_in,
    // link pins
    output wire              capture_serial_clock_out,
    output reg               capture_data_out,
    output reg               select_or_frame_active_pin_out
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function [3:0] first_idx;
        input [1:0] sel;
        begin
            if (sel == `CAP_CONTENT_POWER)
                first_idx = `CAP_IDX_FIRST_POWER;
            else
                first_idx = `CAP_IDX_FIRST_WAVE;
        end
    endfunction

    function [3:0] last_idx;
        input [1:0] sel;
        begin
            if (sel == `CAP_CONTENT_WAVE)
                last_idx = `CAP_IDX_LAST_WAVE;
            else
                last_idx = `CAP_IDX_LAST_POWER;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // states and storage

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SEND = 3'b010;
    localparam [2:0] ST_GAP  = 3'b100;

    reg  [2:0]        state_q;
    reg  [5:0]        cfg_q;
    reg  [5:0]        frame_cfg_q;
    reg  [WORD_W-1:0] words_q [0:N_WORDS-1];
    reg  [WORD_W-1:0] shift_q;
    reg  [3:0]        word_idx_q;
    reg  [3:0]        last_q;
    reg  [4:0]        word_bit_q;
    reg  [5:0]        pkg_bits_q;
    reg  [2:0]        gap_cnt_q;
    reg               final_q;
    integer           i;

    wire       tick;
    wire [5:0] pkg_len;
    wire       pkg_done;
    wire       frame_pol;
    wire       send_now;
    wire       finish;
    wire [WORD_W-1:0] load_word [0:N_WORDS-1];

    // sequence of the full transfer; subsets are windows into it
    assign load_word[0]  = phase_a_current_sample_in;
    assign load_word[1]  = phase_a_voltage_sample_in;
    assign load_word[2]  = phase_b_current_sample_in;
    assign load_word[3]  = phase_b_voltage_sample_in;
    assign load_word[4]  = phase_c_current_sample_in;
    assign load_word[5]  = phase_c_voltage_sample_in;
    assign load_word[6]  = neutral_current_sample_in;
    assign load_word[7]  = phase_a_apparent_power_in;
    assign load_word[8]  = phase_b_apparent_power_in;
    assign load_word[9]  = phase_c_apparent_power_in;
    assign load_word[10] = phase_a_active_power_in;
    assign load_word[11] = phase_b_active_power_in;
    assign load_word[12] = phase_c_active_power_in;
    assign load_word[13] = phase_a_reactive_power_in;
    assign load_word[14] = phase_b_reactive_power_in;
    assign load_word[15] = phase_c_reactive_power_in;

    assign pkg_len = frame_cfg_q[`CAP_BIT_SIZE_SEL] ?
                     `CAP_PKG_LEN_BYTE : `CAP_PKG_LEN_WORD;
    assign pkg_done  = (pkg_bits_q == pkg_len);
    assign frame_pol = frame_cfg_q[`CAP_BIT_POLARITY];
    assign finish    = tick && state_q[1] && pkg_done && final_q;
    assign send_now  = tick && ((state_q[1] && !pkg_done) ||
                       (state_q[1] && !final_q &&
                        !frame_cfg_q[`CAP_BIT_GAP_EN]) ||
                       (state_q[2] &&
                        gap_cnt_q == `CAP_GAP_PERIODS - 3'h1));

    ////////////////////////////////////////////////////////////////////////
    // serial clock

    capture_clk_div u_clk_div (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .run_in      (!state_q[0]),
        .hold_in     (finish),
        .slow_sel_in (frame_cfg_q[`CAP_BIT_CLK_SEL]),
        .tick_out    (tick),
        .sclk_out    (capture_serial_clock_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // register port

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            cfg_q         <= `CAP_CONFIG_RESET;
            reg_rdata_out <= 8'h00;
        end else begin
            if (reg_wr_in && reg_addr_in == `CAP_ADDR_CONFIG)
                cfg_q <= reg_wdata_in[5:0];
            if (!reg_rd_in)
                reg_rdata_out <= 8'h00;
            else if (reg_addr_in == `CAP_ADDR_CONFIG)
                reg_rdata_out <= {2'h0, cfg_q};
            else if (reg_addr_in == `CAP_ADDR_STATUS)
                reg_rdata_out <= {7'h00, !state_q[0]};
            else
                reg_rdata_out <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and serialiser

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q     <= ST_IDLE;
            frame_cfg_q <= `CAP_CONFIG_RESET;
            shift_q     <= {WORD_W{1'b0}};
            word_idx_q  <= 4'h0;
            last_q      <= 4'h0;
            word_bit_q  <= 5'h00;
            pkg_bits_q  <= 6'h00;
            gap_cnt_q   <= 3'h0;
            final_q     <= 1'b0;
            capture_data_out <= 1'b0;
            select_or_frame_active_pin_out <= 1'b1;
            for (i = 0; i < N_WORDS; i = i + 1)
                words_q[i] <= {WORD_W{1'b0}};
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // idle level follows the live polarity setting
                    select_or_frame_active_pin_out <=
                        !cfg_q[`CAP_BIT_POLARITY];
                    if (capture_start_in) begin
                        // config and words are frozen for the whole frame
                        frame_cfg_q <= cfg_q;
                        for (i = 0; i < N_WORDS; i = i + 1)
                            words_q[i] <= load_word[i];
                        word_idx_q <= first_idx(cfg_q[4:3]);
                        last_q     <= last_idx(cfg_q[4:3]);
                        shift_q    <= load_word[first_idx(cfg_q[4:3])];
                        word_bit_q <= 5'h00;
                        pkg_bits_q <= 6'h00;
                        final_q    <= 1'b0;
                        state_q    <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (finish) begin
                        select_or_frame_active_pin_out <= !frame_pol;
                        state_q <= ST_IDLE;
                    end else if (tick && pkg_done &&
                                 frame_cfg_q[`CAP_BIT_GAP_EN]) begin
                        select_or_frame_active_pin_out <= !frame_pol;
                        gap_cnt_q <= 3'h0;
                        state_q   <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        gap_cnt_q <= gap_cnt_q + 3'h1;
                        if (send_now)
                            state_q <= ST_SEND;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase

            if (send_now) begin
                capture_data_out <= shift_q[WORD_W-1];
                select_or_frame_active_pin_out <= frame_pol;
                pkg_bits_q <= pkg_done ? 6'h01 : pkg_bits_q + 6'h01;
                if (word_bit_q == 5'h1F) begin
                    word_bit_q <= 5'h00;
                    word_idx_q <= word_idx_q + 4'h1;
                    shift_q    <= words_q[word_idx_q + 4'h1];
                end else begin
                    word_bit_q <= word_bit_q + 5'h01;
                    shift_q    <= {shift_q[WORD_W-2:0], 1'b0};
                end
                if (word_bit_q == 5'h1F && word_idx_q == last_q)
                    final_q <= 1'b1;
            end
        end
    end

endmodule // high_speed_capture_port

`default_nettype wire

// ---- dummy_end.v ----
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- capture_port_assertions.sv ----
// checker of the capture port: register reads, serial clock, frame pin
// assumes the bench never writes the config register during a frame
`timescale 1ns/100ps
`default_nettype none
module capture_port_checker (
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        capture_start_in,
    input wire logic [31:0] phase_a_current_sample_in,
    input wire logic [31:0] phase_a_apparent_power_in,
    input wire logic        capture_serial_clock_out,
    input wire logic        capture_data_out,
    input wire logic        select_or_frame_active_pin_out
);
    logic [5:0] cfg_q;
    logic       pol_q;
    logic [2:0] hi_q;
    wire        s = capture_serial_clock_out;
    wire        d = capture_data_out;
    wire        pin = select_or_frame_active_pin_out;
    // serial clock high four edges running: surely between frames
    wire        idle = s && (hi_q >= 3'h4);
    wire        msb = (cfg_q[4:3] == 2'h2) ? phase_a_apparent_power_in[31]
                                         : phase_a_current_sample_in[31];
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cfg_q <= 6'h00;
            pol_q <= 1'b0;
            hi_q <= 3'h0;
        end else begin
            if (reg_wr_in && reg_addr_in == 16'hE706)
                cfg_q <= reg_wdata_in[5:0];
            pol_q <= cfg_q[5];
            hi_q <= !s ? 3'h0 : ((hi_q == 3'h7) ? hi_q : hi_q + 3'h1);
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    reset_state_a: assert property (disable iff (1'b0) rst_in |=>
        s && pin && reg_rdata_out == 8'h00) else $error("bad reset state");
    rd_config_a: assert property (reg_rd_in && reg_addr_in == 16'hE706
        |=> reg_rdata_out == {2'h0, cfg_q}) else $error("config read");
    rd_quiet_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data outside its cycle");
    clk_low_a: assert property ($fell(s) |=> (s or (!s[*2] ##1 s)))
        else $error("serial clock low time");
    clk_high_a: assert property ($rose(s) |=> s)
        else $error("serial clock high time");
    data_hold_a: assert property ($rose(s) |-> $stable(d))
        else $error("data moved at sampling edge");
    start_frame_a: assert property (capture_start_in && idle |->
        ##2 ($fell(s) && $changed(pin) && d == msb))
        else $error("frame start");
    idle_pin_a: assert property (idle |-> pin == !pol_q)
        else $error("idle frame pin level");
endmodule // capture_port_checker

bind high_speed_capture_port capture_port_checker i_capture_port_checker (
    .ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .capture_start_in,
    .phase_a_current_sample_in, .phase_a_apparent_power_in,
    .capture_serial_clock_out, .capture_data_out,
    .select_or_frame_active_pin_out);
`default_nettype wire

// ---- capture_receiver.sv ----
// receiver model: takes data on each serial clock rise while framed
// assumes its clock is the port clock; pol_in mirrors the polarity bit
`timescale 1ns/100ps
`default_nettype none
module capture_receiver (
    input wire logic ref_clk_in,
    input wire logic sclk_in,
    input wire logic data_in,
    input wire logic pin_in,
    input wire logic pol_in
);
    logic [31:0] sr_q;
    logic [31:0] words_q[$];
    logic        sp_q = 1'b1;
    logic        ap_q = 1'b0;
    int          bits_q = 0, pkgs_q = 0, per_q = 0, gap_q = 0;
    int          cnt_q = 0, idle_q = 0;
    wire         act = (pin_in === pol_in);
    wire         rise = sclk_in && !sp_q;
    always @(posedge ref_clk_in) begin
        sp_q <= sclk_in;
        ap_q <= act;
        idle_q <= act ? 0 : idle_q + 1;
        cnt_q <= rise ? 1 : cnt_q + 1;
        if (act && !ap_q) begin
            pkgs_q <= pkgs_q + 1;
            gap_q <= idle_q;
        end
        if (rise && act) begin
            per_q <= cnt_q;
            sr_q <= {sr_q[30:0], data_in};
            bits_q <= bits_q + 1;
            if (bits_q % 32 == 31)
                words_q.push_back({sr_q[30:0], data_in});
        end
    end
endmodule // capture_receiver
`default_nettype wire

// ---- high_speed_capture_port_tb.sv ----
// bench of the capture port: register access and one frame per setting
// assumes the receiver model and the bound checker beside the port
`timescale 1ns/100ps
`default_nettype none
module high_speed_capture_port_tb;
    logic        ref_clk_in = 0, rst_in = 1, pol = 0;
    logic        reg_wr_in = 0, reg_rd_in = 0, capture_start_in = 0;
    logic [15:0] reg_addr_in = 16'h0000;
    logic [7:0]  reg_wdata_in = 8'h00;
    wire  [7:0]  reg_rdata_out;
    wire         capture_serial_clock_out, capture_data_out;
    wire         select_or_frame_active_pin_out;
    logic [31:0] w [16];
    int          failures = 0, num_checks = 0;
    always #20 ref_clk_in = ~ref_clk_in;
    initial for (int i = 0; i < 16; i++) w[i] = 32'h8421_0F00 + i * 32'h0111_1001;
    high_speed_capture_port i_high_speed_capture_port (.ref_clk_in, .rst_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .capture_start_in, .capture_serial_clock_out, .capture_data_out,
        .select_or_frame_active_pin_out,
        .phase_a_current_sample_in(w[0]), .phase_a_voltage_sample_in(w[1]),
        .phase_b_current_sample_in(w[2]), .phase_b_voltage_sample_in(w[3]),
        .phase_c_current_sample_in(w[4]), .phase_c_voltage_sample_in(w[5]),
        .neutral_current_sample_in(w[6]), .phase_a_apparent_power_in(w[7]),
        .phase_b_apparent_power_in(w[8]), .phase_c_apparent_power_in(w[9]),
        .phase_a_active_power_in(w[10]), .phase_b_active_power_in(w[11]),
        .phase_c_active_power_in(w[12]), .phase_a_reactive_power_in(w[13]),
        .phase_b_reactive_power_in(w[14]), .phase_c_reactive_power_in(w[15]));
    capture_receiver i_capture_receiver (.ref_clk_in,
        .sclk_in(capture_serial_clock_out), .data_in(capture_data_out),
        .pin_in(select_or_frame_active_pin_out), .pol_in(pol));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // callers enter just after a rising edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1;
        @(posedge ref_clk_in);
        reg_wr_in <= 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        reg_addr_in <= a;
        reg_rd_in <= 1;
        @(posedge ref_clk_in);
        reg_rd_in <= 0;
        // read data stand only in the cycle after the strobe
        @(negedge ref_clk_in);
        chk(reg_rdata_out, e);
        @(posedge ref_clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic regs;
        rd(16'hE706, 8'h00);
        wr(16'hE706, 8'hFF);
        rd(16'hE706, 8'h3F);
        wr(16'hE700, 8'h55);
        rd(16'hE706, 8'h3F);
        rd(16'hE700, 8'h00);
        rd(16'hE7F0, 8'h00);
        wr(16'hE706, 8'h00);
        $display("register test done");
    endtask
    task automatic frame(input logic [7:0] c, input int first, input int n);
        int b0, p0, k, per;
        wr(16'hE706, c);
        @(posedge ref_clk_in);
        pol <= c[5];
        @(posedge ref_clk_in);
        b0 = i_capture_receiver.bits_q;
        p0 = i_capture_receiver.pkgs_q;
        i_capture_receiver.words_q.delete();
        capture_start_in <= 1;
        @(posedge ref_clk_in);
        capture_start_in <= 0;
        repeat (8) @(posedge ref_clk_in);
        // a second start mid-frame must change nothing
        capture_start_in <= 1;
        rd(16'hE7F0, 8'h01);
        capture_start_in <= 0;
        for (k = 0; k < 30000 && i_capture_receiver.bits_q - b0 < n * 32; k++)
            @(posedge ref_clk_in);
        if (k == 30000) begin
            failures++;
            stop_test();
        end
        repeat (20) @(posedge ref_clk_in);
        per = c[0] ? 6 : 3;
        chk(i_capture_receiver.bits_q - b0, n * 32);
        for (k = 0; k < n; k++)
            chk(i_capture_receiver.words_q[k], w[first + k]);
        chk(i_capture_receiver.per_q, per);
        chk(i_capture_receiver.pkgs_q - p0, c[2] ? n * (c[1] ? 4 : 1) : 1);
        if (c[2])
            chk(i_capture_receiver.gap_q, 7 * per);
        chk(select_or_frame_active_pin_out, !c[5]);
        $display("frame test %h done", c);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 0;
        @(posedge ref_clk_in);
        regs();
        frame(8'h00, 0, 16);
        frame(8'h08, 0, 7);
        frame(8'h16, 7, 9);
        frame(8'h39, 0, 16);
        stop_test();
    end
endmodule // high_speed_capture_port_tb
`default_nettype wire
